/* src/period_timer_pkg.sv */
`default_nettype none
package period_timer_pkg;
   localparam logic [7:0] ADDR_GLOBAL_INT = 8'h0B;
   localparam logic [7:0] ADDR_INT_FLAGS = 8'h0C;
   localparam logic [7:0] ADDR_COUNT = 8'h11;
   localparam logic [7:0] ADDR_CONTROL = 8'h12;
   localparam logic [7:0] ADDR_INT_ENABLES = 8'h8C;
   localparam logic [7:0] ADDR_PERIOD = 8'h92;

   localparam int GLOBAL_EN_BIT = 7;
   localparam int PERIPH_EN_BIT = 6;
   localparam int MATCH_FLAG_BIT = 1;

   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'hFF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] COUNT_ONE = 8'h01;

   // instruction clock is the system clock divided by four
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [1:0] PHASE_ONE = 2'h1;
   localparam logic [3:0] PRE_LAST_DIV1 = 4'h0;
   localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
   localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;
   localparam logic [3:0] SCALE_ZERO = 4'h0;
   localparam logic [3:0] SCALE_ONE = 4'h1;
   localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
   localparam logic [1:0] PRESCALE_DIV4 = 2'h1;

   typedef struct packed {
      logic [3:0] output_postscale_field;
      logic timer_on_bit;
      logic [1:0] clock_prescale_field;
   } timer_ctrl_s;

   localparam timer_ctrl_s CTRL_RESET = '{output_postscale_field: 4'h0, timer_on_bit: 1'b0,
                                          clock_prescale_field: 2'h0};

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;
endpackage : period_timer_pkg
`default_nettype wire

/* src/period_match_timer_8bit.sv */
// Contract
// [RULE_01] The counter advances from the instruction clock through a 1, 4 or 16 prescaler chosen by the prescale field.
// [RULE_02] The counter counts up from zero and returns to zero on the increment after it equals the period limit.
// [RULE_03] Each match passes a 4-bit postscaler whose output sets the match flag at bit 1 of the flag register.
// [RULE_04] The postscale field in control bits 6 to 3 selects a ratio of its value plus one.
// [RULE_05] The counter advances only while the timer-on bit is one.
// [RULE_06] A write to the counter or control register and any reset clear the prescale and postscale counts.
// [RULE_07] A write to the control register leaves the counter value as it was.
// [RULE_08] The counter is readable and writable and is zero after reset.
// [RULE_09] The period limit is readable and writable and is FFh after reset.
// [RULE_10] The counter and its match event are offered as the time base of the PWM unit.
// [RULE_11] Control bit 7 reads as zero and ignores writes.
// [RULE_12] The match flag stays set until software writes it to zero, and the request is high while flag and enable are set.
// [RULE_13] The postscaler counts matches, sets the flag at the chosen ratio and then restarts from zero.
//
// The plain strobed port was chosen for this implementation.
`default_nettype none
module period_match_timer_8bit (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire period_timer_pkg::bus_req_s i_bus,
   output logic [7:0] o_rdata,
   output logic o_irq,
   output logic [7:0] o_pwm_count,
   output logic o_pwm_match
);
   import period_timer_pkg::*;

   logic [1:0] phase;
   logic [1:0] next_phase;
   logic [3:0] pre_cnt;
   logic [3:0] next_pre_cnt;
   logic [3:0] post_cnt;
   logic [3:0] next_post_cnt;
   logic [7:0] period_timer_count;
   logic [7:0] next_period_timer_count;
   logic [7:0] period_limit;
   logic [7:0] next_period_limit;
   timer_ctrl_s period_timer_control;
   timer_ctrl_s next_period_timer_control;
   logic timer_match_flag;
   logic next_timer_match_flag;
   logic timer_match_enable;
   logic next_timer_match_enable;
   logic global_en;
   logic next_global_en;
   logic periph_en;
   logic next_periph_en;
   logic [7:0] next_rdata;
   logic next_irq;
   logic next_pwm_match;

   logic inst_tick;
   logic [3:0] pre_last;
   logic inc;
   logic match;
   logic post_hit;
   logic wr_count;
   logic wr_ctrl;
   logic wr_flags;

   assign wr_count = i_bus.wr && (i_bus.addr == ADDR_COUNT);
   assign wr_ctrl = i_bus.wr && (i_bus.addr == ADDR_CONTROL);
   assign wr_flags = i_bus.wr && (i_bus.addr == ADDR_INT_FLAGS);

   // timing chain: instruction clock, prescaler, counter, postscaler
   always_comb begin
      next_phase = phase + PHASE_ONE;
      inst_tick = (phase == PHASE_LAST);
      case (period_timer_control.clock_prescale_field)
         PRESCALE_DIV1: pre_last = PRE_LAST_DIV1; // RULE_01
         PRESCALE_DIV4: pre_last = PRE_LAST_DIV4; // RULE_01
         default: pre_last = PRE_LAST_DIV16; // RULE_01
      endcase
      // a counter or control write in the same cycle wins over an increment, so the written value is never skewed
      inc = inst_tick && period_timer_control.timer_on_bit && (pre_cnt == pre_last)
            && !wr_count && !wr_ctrl; // RULE_05
      match = inc && (period_timer_count == period_limit); // RULE_02
      post_hit = match && (post_cnt == period_timer_control.output_postscale_field); // RULE_04

      next_pre_cnt = pre_cnt;
      if (wr_count || wr_ctrl) begin
         next_pre_cnt = SCALE_ZERO; // RULE_06
      end else if (inst_tick && period_timer_control.timer_on_bit) begin
         next_pre_cnt = (pre_cnt == pre_last) ? SCALE_ZERO : pre_cnt + SCALE_ONE; // RULE_01
      end

      next_post_cnt = post_cnt;
      if (wr_count || wr_ctrl) begin
         next_post_cnt = SCALE_ZERO; // RULE_06
      end else if (post_hit) begin
         next_post_cnt = SCALE_ZERO; // RULE_13
      end else if (match) begin
         next_post_cnt = post_cnt + SCALE_ONE; // RULE_13
      end

      next_period_timer_count = period_timer_count; // RULE_07
      if (wr_count) begin
         next_period_timer_count = i_bus.wdata; // RULE_08
      end else if (match) begin
         next_period_timer_count = COUNT_RESET; // RULE_02
      end else if (inc) begin
         next_period_timer_count = period_timer_count + COUNT_ONE; // RULE_02
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         phase <= PHASE_LAST ^ PHASE_LAST;
         pre_cnt <= SCALE_ZERO; // RULE_06
         post_cnt <= SCALE_ZERO; // RULE_06
         period_timer_count <= COUNT_RESET; // RULE_08
      end else begin
         phase <= next_phase;
         pre_cnt <= next_pre_cnt;
         post_cnt <= next_post_cnt;
         period_timer_count <= next_period_timer_count;
      end
   end

   // software registers and the interrupt path
   always_comb begin
      next_period_limit = period_limit;
      next_period_timer_control = period_timer_control;
      next_timer_match_enable = timer_match_enable;
      next_global_en = global_en;
      next_periph_en = periph_en;
      if (i_bus.wr) begin
         case (i_bus.addr)
            ADDR_PERIOD: next_period_limit = i_bus.wdata; // RULE_09
            ADDR_CONTROL: next_period_timer_control = timer_ctrl_s'(i_bus.wdata[6:0]); // RULE_11
            ADDR_INT_ENABLES: next_timer_match_enable = i_bus.wdata[MATCH_FLAG_BIT];
            ADDR_GLOBAL_INT: begin
               next_global_en = i_bus.wdata[GLOBAL_EN_BIT];
               next_periph_en = i_bus.wdata[PERIPH_EN_BIT];
            end
            default: next_period_limit = period_limit;
         endcase
      end
      // a postscaler hit landing on the clearing write still sets the flag
      next_timer_match_flag = post_hit | (wr_flags ? i_bus.wdata[MATCH_FLAG_BIT] : timer_match_flag); // RULE_03
      next_irq = next_timer_match_flag && next_timer_match_enable; // RULE_12
      next_pwm_match = match; // RULE_10

      next_rdata = ZERO_BYTE;
      if (i_bus.rd) begin
         case (i_bus.addr)
            ADDR_COUNT: next_rdata = period_timer_count;
            ADDR_PERIOD: next_rdata = period_limit;
            ADDR_CONTROL: next_rdata = {1'b0, period_timer_control}; // RULE_11
            ADDR_INT_FLAGS: next_rdata = ZERO_BYTE | ({7'h00, timer_match_flag} << MATCH_FLAG_BIT);
            ADDR_INT_ENABLES: next_rdata = ZERO_BYTE | ({7'h00, timer_match_enable} << MATCH_FLAG_BIT);
            ADDR_GLOBAL_INT: next_rdata = ({7'h00, global_en} << GLOBAL_EN_BIT)
                                          | ({7'h00, periph_en} << PERIPH_EN_BIT);
            default: next_rdata = ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         period_limit <= PERIOD_RESET; // RULE_09
         period_timer_control <= CTRL_RESET;
         timer_match_flag <= 1'b0;
         timer_match_enable <= 1'b0;
         global_en <= 1'b0;
         periph_en <= 1'b0;
         o_rdata <= ZERO_BYTE;
         o_irq <= 1'b0;
         o_pwm_match <= 1'b0;
         o_pwm_count <= COUNT_RESET;
      end else begin
         period_limit <= next_period_limit;
         period_timer_control <= next_period_timer_control;
         timer_match_flag <= next_timer_match_flag;
         timer_match_enable <= next_timer_match_enable;
         global_en <= next_global_en;
         periph_en <= next_periph_en;
         o_rdata <= next_rdata;
         o_irq <= next_irq;
         o_pwm_match <= next_pwm_match;
         o_pwm_count <= next_period_timer_count; // RULE_10
      end
   end

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);

   prescale_sixteen_a: assert property (inc && period_timer_control.clock_prescale_field[1]
      |-> pre_cnt == PRE_LAST_DIV16 && inst_tick) // RULE_01
      else $error("increment before sixteen instruction ticks");
   prescale_four_a: assert property (inc && period_timer_control.clock_prescale_field == PRESCALE_DIV4
      |-> pre_cnt == PRE_LAST_DIV4 && inst_tick) // RULE_01
      else $error("divide by four increment misplaced");
   prescale_one_a: assert property (inc && period_timer_control.clock_prescale_field == PRESCALE_DIV1
      |-> pre_cnt == PRE_LAST_DIV1 && inst_tick) // RULE_01
      else $error("divide by one increment misplaced");
   pre_restart_a: assert property (inc |=> pre_cnt == SCALE_ZERO) // RULE_01
      else $error("prescaler did not restart after an increment");
   phase_step_a: assert property (1'b1 |=> phase == $past(phase) + PHASE_ONE) // RULE_01
      else $error("instruction phase did not advance");
   wrap_zero_a: assert property (inc && period_timer_count == period_limit |=> period_timer_count == COUNT_RESET
      ##0 o_pwm_match) // RULE_02
      else $error("counter did not wrap to zero on match");
   count_step_a: assert property (inc && period_timer_count != period_limit
      |=> period_timer_count == $past(period_timer_count) + COUNT_ONE) // RULE_02
      else $error("counter did not step by one");
   post_flag_a: assert property (post_hit |=> timer_match_flag && post_cnt == SCALE_ZERO) // RULE_03
      else $error("postscaler output did not set the flag");
   post_ratio_a: assert property (match && post_cnt != period_timer_control.output_postscale_field
      |=> post_cnt == $past(post_cnt) + SCALE_ONE) // RULE_13
      else $error("postscaler did not count a match");
   ratio_fire_a: assert property (post_hit |-> post_cnt == period_timer_control.output_postscale_field) // RULE_04
      else $error("flag set at the wrong ratio");
   timer_off_a: assert property (!period_timer_control.timer_on_bit && !wr_count
      |=> period_timer_count == $past(period_timer_count)) // RULE_05
      else $error("counter moved while the timer was off");
   clear_scalers_a: assert property (wr_count || wr_ctrl |=> pre_cnt == SCALE_ZERO && post_cnt == SCALE_ZERO) // RULE_06
      else $error("scalers not cleared by register write");
   ctrl_keeps_count_a: assert property (wr_ctrl |=> period_timer_count == $past(period_timer_count)) // RULE_07
      else $error("control write disturbed the counter");
   count_write_a: assert property (wr_count |=> period_timer_count == $past(i_bus.wdata)) // RULE_08
      else $error("counter write not taken");
   top_bit_zero_a: assert property (i_bus.rd && i_bus.addr == ADDR_CONTROL |=> !o_rdata[7]) // RULE_11
      else $error("control bit 7 read as one");
   flag_sticky_a: assert property (timer_match_flag && !wr_flags |=> timer_match_flag [*1]) // RULE_12
      else $error("match flag dropped without a write");
   irq_level_a: assert property (timer_match_flag && timer_match_enable |-> o_irq) // RULE_12
      else $error("request low while flag and enable set");
   irq_quiet_a: assert property (!(timer_match_flag && timer_match_enable) |-> !o_irq) // RULE_12
      else $error("request high without flag and enable");
   flag_clear_a: assert property (wr_flags && !i_bus.wdata[MATCH_FLAG_BIT] && !post_hit
      |=> !timer_match_flag) // RULE_12
      else $error("match flag not cleared by a zero write");
   off_scalers_a: assert property (!period_timer_control.timer_on_bit && !wr_count && !wr_ctrl
      |=> pre_cnt == $past(pre_cnt) && post_cnt == $past(post_cnt)) // RULE_05
      else $error("scalers moved while the timer was off");
   period_write_a: assert property (i_bus.wr && i_bus.addr == ADDR_PERIOD
      |=> period_limit == $past(i_bus.wdata)) // RULE_09
      else $error("period write not taken");
   period_read_a: assert property (i_bus.rd && i_bus.addr == ADDR_PERIOD
      |=> o_rdata == $past(period_limit)) // RULE_09
      else $error("period read returned a wrong value");
   count_read_a: assert property (i_bus.rd && i_bus.addr == ADDR_COUNT
      |=> o_rdata == $past(period_timer_count)) // RULE_08
      else $error("counter read returned a wrong value");
   ctrl_write_a: assert property (wr_ctrl
      |=> period_timer_control == timer_ctrl_s'($past(i_bus.wdata[6:0]))) // RULE_11
      else $error("control write not taken");
   rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == ZERO_BYTE)
      else $error("read data present without a read");
   pwm_count_copy_a: assert property (o_pwm_count == period_timer_count) // RULE_10
      else $error("time base count differs from the counter");
   pwm_pulse_zero_a: assert property (o_pwm_match |-> period_timer_count == COUNT_RESET) // RULE_10
      else $error("time base pulse without a wrapped counter");
   pwm_no_pulse_a: assert property (!match |=> !o_pwm_match) // RULE_10
      else $error("time base pulse without a match");
   post_hold_a: assert property (!match && !wr_count && !wr_ctrl
      |=> post_cnt == $past(post_cnt)) // RULE_13
      else $error("postscaler moved without a match");

   wrap_seen_c: cover property (match ##1 o_pwm_match);
   flag_set_c: cover property (post_hit && period_timer_control.output_postscale_field == 4'hF);
   clear_race_c: cover property (wr_flags && post_hit);
   ctrl_write_c: cover property (period_timer_control.timer_on_bit && wr_ctrl);
endmodule : period_match_timer_8bit
`default_nettype wire

/* verification/period_match_timer_8bit_test.sv */
`default_nettype none
module period_match_timer_8bit_test;
   timeunit 1ns;
   timeprecision 1ps;
   import period_timer_pkg::*;

   logic i_ref_clk;
   logic i_sys_rst;
   bus_req_s bus;
   logic [7:0] rdata;
   logic [7:0] pcount;
   logic irq;
   logic pmatch;
   int err_total;
   int cmp_count;
   int cycles;

   period_match_timer_8bit dut_u (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_bus(bus),
      .o_rdata(rdata),
      .o_irq(irq),
      .o_pwm_count(pcount),
      .o_pwm_match(pmatch)
   );

   initial begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end

   task automatic close_out;
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   // a hang past this many cycles is counted as a mismatch
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         close_out();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge i_ref_clk);
      bus.wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_ref_clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge i_ref_clk);
      bus.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd_chk

   task automatic wait_match(output int n);
      n = 0;
      do begin
         @(negedge i_ref_clk);
         n++;
      end while (pmatch !== 1'b1 && n < 1000);
   endtask : wait_match

   task automatic t_regs;
      rd_chk(ADDR_COUNT, 8'h00);
      rd_chk(ADDR_PERIOD, 8'hFF);
      rd_chk(ADDR_CONTROL, 8'h00);
      rd_chk(ADDR_INT_FLAGS, 8'h00);
      rd_chk(ADDR_INT_ENABLES, 8'h00);
      rd_chk(ADDR_GLOBAL_INT, 8'h00);
      rd_chk(8'h40, 8'h00);
      wr(ADDR_CONTROL, 8'hFF);
      rd_chk(ADDR_CONTROL, 8'h7F);
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_PERIOD, 8'hA5);
      rd_chk(ADDR_PERIOD, 8'hA5);
      wr(ADDR_COUNT, 8'h3C);
      rd_chk(ADDR_COUNT, 8'h3C);
      wr(ADDR_CONTROL, 8'h78);
      rd_chk(ADDR_COUNT, 8'h3C);
      wr(ADDR_GLOBAL_INT, 8'hC0);
      rd_chk(ADDR_GLOBAL_INT, 8'hC0);
   endtask : t_regs

   // period 2 gives three counts per wrap: 12, 48 or 192 clocks between matches
   task automatic t_prescale;
      int n;
      logic [7:0] exp [4] = '{8'h0C, 8'h30, 8'hC0, 8'hC0};
      wr(ADDR_PERIOD, 8'h02);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CONTROL, 8'h04 | 8'(i));
         wait_match(n);
         chk(pcount, 8'h00);
         wait_match(n);
         chk(8'(n), exp[i]);
      end
   endtask : t_prescale

   task automatic t_postscale;
      int m;
      logic [3:0] ratios [3] = '{4'h0, 4'h1, 4'hF};
      wr(ADDR_INT_ENABLES, 8'h02);
      foreach (ratios[k]) begin
         wr(ADDR_CONTROL, 8'h00);
         wr(ADDR_INT_FLAGS, 8'h00);
         wr(ADDR_COUNT, 8'h00);
         wr(ADDR_CONTROL, {1'b0, ratios[k], 3'b100});
         m = 0;
         for (int c = 0; c < 4000 && irq !== 1'b1; c++) begin
            @(negedge i_ref_clk);
            if (pmatch === 1'b1)
               m++;
         end
         chk(8'(m), {4'h0, ratios[k]} + 8'h01);
      end
      wr(ADDR_CONTROL, 8'h00);
      rd_chk(ADDR_INT_FLAGS, 8'h02);
      wr(ADDR_INT_ENABLES, 8'h00);
      @(negedge i_ref_clk);
      chk({7'h00, irq}, 8'h00);
      wr(ADDR_INT_ENABLES, 8'h02);
      @(negedge i_ref_clk);
      chk({7'h00, irq}, 8'h01);
      wr(ADDR_INT_FLAGS, 8'h00);
      @(negedge i_ref_clk);
      chk({7'h00, irq}, 8'h00);
   endtask : t_postscale

   // the instruction phase is free running, so the first step after a count write lands 61 to 64 clocks later
   task automatic t_stop_and_clear;
      wr(ADDR_PERIOD, 8'hFF);
      wr(ADDR_CONTROL, 8'h06);
      repeat (40) @(negedge i_ref_clk);
      wr(ADDR_COUNT, 8'h10);
      repeat (59) @(negedge i_ref_clk);
      chk(pcount, 8'h10);
      repeat (9) @(negedge i_ref_clk);
      chk(pcount, 8'h11);
      wr(ADDR_CONTROL, 8'h02);
      wr(ADDR_COUNT, 8'h77);
      repeat (300) @(negedge i_ref_clk);
      rd_chk(ADDR_COUNT, 8'h77);
   endtask : t_stop_and_clear

   // a reset in mid-run must bring back the power-up values
   task automatic t_reset;
      wr(ADDR_PERIOD, 8'h33);
      wr(ADDR_CONTROL, 8'h04);
      @(posedge i_ref_clk);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      @(negedge i_ref_clk);
      chk(pcount, 8'h00);
      rd_chk(ADDR_PERIOD, 8'hFF);
      rd_chk(ADDR_CONTROL, 8'h00);
   endtask : t_reset

   initial begin
      err_total = 0;
      cmp_count = 0;
      cycles = 0;
      bus = '0;
      i_sys_rst = 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      t_regs();
      t_prescale();
      t_postscale();
      t_stop_and_clear();
      t_reset();
      close_out();
   end
endmodule : period_match_timer_8bit_test
`default_nettype wire
